/* File: src/ppsr_pkg.sv */
// package of constants for the pin port with sleep retention
// assumes a single 125 MHz clock and a plain byte-addressed register port
package ppsr_pkg;

   // ***************************************************************
   // sizes
   // ***************************************************************
   localparam int NUM_PINS = 20;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   // ***************************************************************
   // register byte offsets
   // ***************************************************************
   localparam logic [7:0] OFF_DIR = 8'h00;
   localparam logic [7:0] OFF_OUT = 8'h04;
   localparam logic [7:0] OFF_PULL = 8'h08;
   localparam logic [7:0] OFF_IN = 8'h0C;
   localparam logic [7:0] OFF_INTEN = 8'h10;
   localparam logic [7:0] OFF_STAT = 8'h14;
   localparam logic [7:0] OFF_MASK = 8'h18;
   localparam logic [7:0] OFF_CTRL = 8'h1C;
   localparam logic [7:0] OFF_ALT = 8'h20;

   // ***************************************************************
   // field positions and reset values
   // ***************************************************************
   localparam int CTRL_TWOWIRE = 0;
   localparam int CTRL_ADC_EN = 1;
   localparam int CTRL_CMP_EN = 2;
   localparam int CTRL_CMP_WAKE = 3;
   localparam int CTRL_W = 4;
   localparam int STAT_CMP_BIT = 20;
   localparam int STAT_W = 21;
   localparam int PIN_TW_A = 4;
   localparam int PIN_TW_B = 5;
   localparam logic [19:0] TW_PIN_MASK = 20'h00030;
   localparam logic [19:0] PULL_RESET = 20'hFFFFF;
   localparam logic [3:0] CTRL_RESET = 4'h0;

   // ***************************************************************
   // timing
   // ***************************************************************
   localparam int CLK_PERIOD_NS = 8;
   localparam int GLITCH_NS = 50;
   localparam int GLITCH_CYC = (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int FILT_CNT_W = 3;
   localparam logic [2:0] GLITCH_LAST = 3'(GLITCH_CYC - 1);

endpackage : ppsr_pkg

/* File: src/ppsr_glitch_filter.sv */
// input glitch filter for the two-wire capable pins
// assumes its input is already synchronised to clk
`timescale 1ns/100ps
module ppsr_glitch_filter (
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // filtered line
   input wire logic rawIn,
   output logic cleanOut
);

   logic [ppsr_pkg::FILT_CNT_W-1:0] cnt_ff;
   logic clean_ff;

   // a new level is taken only after it held for the whole glitch window
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_ff <= 3'h0;
         clean_ff <= 1'b1;
      end else if (rawIn == clean_ff) begin
         cnt_ff <= 3'h0;
      end else if (cnt_ff == ppsr_pkg::GLITCH_LAST) begin
         cnt_ff <= 3'h0;
         clean_ff <= rawIn;
      end else begin
         cnt_ff <= cnt_ff + 3'h1;
      end
   end

   assign cleanOut = clean_ff;

   // ***************************************************************
   // checks
   // ***************************************************************
   property p_filter_change;
      @(posedge clk) disable iff (!arst_n)
      (clean_ff != $past(clean_ff)) |-> (clean_ff == $past(rawIn));
   endproperty
   a_filter_change: assert property (p_filter_change) else $error("filter output moved without input");

endmodule : ppsr_glitch_filter

/* File: src/ppsr_port.sv */
// general pin port: direction, level, pull, peripheral hand-over, two-wire
// open-drain mode, sleep retention, wake and interrupt
// assumes pins sampled on clk, a power manager giving sleep levels
//
// The strobed register port and the address map were left to the implementer.
`timescale 1ns/100ps
module ppsr_port (
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // register port
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [31:0] regRdata,
   // pads
   input wire logic [19:0] pinIn,
   output logic [19:0] pinOut,
   output logic [19:0] pinOe,
   output logic [19:0] pullEn,
   // secondary-function peripherals
   output logic [19:0] periphEn,
   input wire logic [19:0] periphOe,
   input wire logic [19:0] periphOut,
   output logic [19:0] periphIn,
   // analog blocks
   output logic adcEn,
   output logic cmpEn,
   input wire logic cmpEvent,
   // power management
   input wire logic sleepReq,
   input wire logic deepSleepReq,
   output logic wakeReq,
   output logic irq
);

   localparam int N = ppsr_pkg::NUM_PINS;

   // ***************************************************************
   // registers
   // ***************************************************************
   logic [N-1:0] dir_ff;
   logic [N-1:0] outReg_ff;
   logic [N-1:0] pull_ff;
   logic [N-1:0] intEn_ff;
   logic [N-1:0] alt_ff;
   logic [ppsr_pkg::STAT_W-1:0] stat_ff;
   logic [ppsr_pkg::STAT_W-1:0] mask_ff;
   logic [ppsr_pkg::CTRL_W-1:0] ctrl_ff;
   logic [N-1:0] syncA_ff;
   logic [N-1:0] syncB_ff;
   logic [N-1:0] prevIn_ff;
   logic [N-1:0] pinOut_ff;
   logic [N-1:0] pinOe_ff;
   logic [N-1:0] periphIn_ff;
   logic [31:0] rdata_ff;
   logic adcEn_ff;
   logic cmpEn_ff;
   logic wake_ff;
   logic irq_ff;

   // ***************************************************************
   // address decode
   // ***************************************************************
   wire wrDir = regWr && (regAddr == ppsr_pkg::OFF_DIR);
   wire wrOut = regWr && (regAddr == ppsr_pkg::OFF_OUT);
   wire wrPull = regWr && (regAddr == ppsr_pkg::OFF_PULL);
   wire wrIntEn = regWr && (regAddr == ppsr_pkg::OFF_INTEN);
   wire wrStat = regWr && (regAddr == ppsr_pkg::OFF_STAT);
   wire wrMask = regWr && (regAddr == ppsr_pkg::OFF_MASK);
   wire wrCtrl = regWr && (regAddr == ppsr_pkg::OFF_CTRL);
   wire wrAlt = regWr && (regAddr == ppsr_pkg::OFF_ALT);

   wire [N-1:0] wPins = regWdata[N-1:0];
   wire twoWire = ctrl_ff[ppsr_pkg::CTRL_TWOWIRE];
   wire asleep = sleepReq || deepSleepReq;

   // ***************************************************************
   // input path
   // ***************************************************************
   // first stage is read only by the second
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         syncA_ff <= '0;
         syncB_ff <= '0;
      end else begin
         syncA_ff <= pinIn;
         syncB_ff <= syncA_ff;
      end
   end

   logic filtA;
   logic filtB;

   ppsr_glitch_filter u_filt_a (
      .clk(clk),
      .arst_n(arst_n),
      .rawIn(syncB_ff[ppsr_pkg::PIN_TW_A]),
      .cleanOut(filtA)
   );

   ppsr_glitch_filter u_filt_b (
      .clk(clk),
      .arst_n(arst_n),
      .rawIn(syncB_ff[ppsr_pkg::PIN_TW_B]),
      .cleanOut(filtB)
   );

   // two-wire pins read through the filter while in two-wire mode
   wire [N-1:0] filtPins = {syncB_ff[N-1:ppsr_pkg::PIN_TW_B+1], filtB, filtA, syncB_ff[ppsr_pkg::PIN_TW_A-1:0]};
   wire [N-1:0] pinVal = twoWire ? filtPins : syncB_ff;

   // ***************************************************************
   // output path
   // ***************************************************************
   // peripheral-owned pins take direction and level from the peripheral
   wire [N-1:0] srcOe = (alt_ff & periphOe) | (~alt_ff & dir_ff);
   wire [N-1:0] srcOut = (alt_ff & periphOut) | (~alt_ff & outReg_ff);
   wire [N-1:0] twMask = twoWire ? ppsr_pkg::TW_PIN_MASK : '0;
   // open drain: drive only low, release for high
   wire [N-1:0] nxt_pinOe = (srcOe & ~twMask) | (srcOe & ~srcOut & twMask);
   wire [N-1:0] nxt_pinOut = srcOut & ~twMask;

   // pads freeze while asleep, so direction and level are retained
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pinOe_ff <= '0;
         pinOut_ff <= '0;
      end else if (!asleep) begin
         pinOe_ff <= nxt_pinOe;
         pinOut_ff <= nxt_pinOut;
      end
   end

   // ***************************************************************
   // configuration registers
   // ***************************************************************
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         dir_ff <= '0;
         outReg_ff <= '0;
         intEn_ff <= '0;
      end else begin
         if (wrDir) dir_ff <= wPins;
         if (wrOut) outReg_ff <= wPins;
         if (wrIntEn) intEn_ff <= wPins;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pull_ff <= ppsr_pkg::PULL_RESET;
         alt_ff <= '0;
         ctrl_ff <= ppsr_pkg::CTRL_RESET;
         mask_ff <= '0;
      end else begin
         if (wrPull) pull_ff <= wPins;
         if (wrAlt) alt_ff <= wPins;
         if (wrCtrl) ctrl_ff <= regWdata[ppsr_pkg::CTRL_W-1:0];
         if (wrMask) mask_ff <= regWdata[ppsr_pkg::STAT_W-1:0];
      end
   end

   // ***************************************************************
   // events, status, interrupt and wake
   // ***************************************************************
   // only pins held as inputs with interrupt enabled report changes
   wire [N-1:0] pinEvt = (pinVal ^ prevIn_ff) & intEn_ff & ~pinOe_ff;
   wire cmpEvt = cmpEvent && cmpEn_ff;
   wire [ppsr_pkg::STAT_W-1:0] statSet = {cmpEvt, pinEvt};
   wire [ppsr_pkg::STAT_W-1:0] statClr = wrStat ? regWdata[ppsr_pkg::STAT_W-1:0] : '0;
   // a set in the same cycle as its clear wins
   wire [ppsr_pkg::STAT_W-1:0] nxt_stat = (stat_ff & ~statClr) | statSet;
   wire cmpWake = cmpEvt && ctrl_ff[ppsr_pkg::CTRL_CMP_WAKE] && !deepSleepReq;
   wire nxt_wake = asleep && (wake_ff || (|pinEvt) || cmpWake);

   // comparator survives light sleep only when used as a wake source
   wire cmpKeep = sleepReq && !deepSleepReq && ctrl_ff[ppsr_pkg::CTRL_CMP_WAKE];
   wire nxt_cmpEn = ctrl_ff[ppsr_pkg::CTRL_CMP_EN] && (!asleep || cmpKeep);
   wire nxt_adcEn = ctrl_ff[ppsr_pkg::CTRL_ADC_EN] && !asleep;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         prevIn_ff <= '0;
         stat_ff <= '0;
         wake_ff <= 1'b0;
         irq_ff <= 1'b0;
      end else begin
         prevIn_ff <= pinVal;
         stat_ff <= nxt_stat;
         wake_ff <= nxt_wake;
         irq_ff <= |(nxt_stat & mask_ff);
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         adcEn_ff <= 1'b0;
         cmpEn_ff <= 1'b0;
         periphIn_ff <= '0;
      end else begin
         adcEn_ff <= nxt_adcEn;
         cmpEn_ff <= nxt_cmpEn;
         periphIn_ff <= pinVal;
      end
   end

   // ***************************************************************
   // read data
   // ***************************************************************
   wire [31:0] rdMux =
      (regAddr == ppsr_pkg::OFF_DIR) ? 32'(dir_ff) :
      (regAddr == ppsr_pkg::OFF_OUT) ? 32'(outReg_ff) :
      (regAddr == ppsr_pkg::OFF_PULL) ? 32'(pull_ff) :
      (regAddr == ppsr_pkg::OFF_IN) ? 32'(pinVal) :
      (regAddr == ppsr_pkg::OFF_INTEN) ? 32'(intEn_ff) :
      (regAddr == ppsr_pkg::OFF_STAT) ? 32'(stat_ff) :
      (regAddr == ppsr_pkg::OFF_MASK) ? 32'(mask_ff) :
      (regAddr == ppsr_pkg::OFF_CTRL) ? 32'(ctrl_ff) :
      (regAddr == ppsr_pkg::OFF_ALT) ? 32'(alt_ff) : 32'h00000000;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rdata_ff <= 32'h00000000;
      end else begin
         rdata_ff <= regRd ? rdMux : 32'h00000000;
      end
   end

   // ***************************************************************
   // outputs
   // ***************************************************************
   assign regRdata = rdata_ff;
   assign pinOut = pinOut_ff;
   assign pinOe = pinOe_ff;
   assign pullEn = pull_ff;
   assign periphEn = alt_ff;
   assign periphIn = periphIn_ff;
   assign adcEn = adcEn_ff;
   assign cmpEn = cmpEn_ff;
   assign wakeReq = wake_ff;
   assign irq = irq_ff;

   // ***************************************************************
   // checks
   // ***************************************************************
   property p_gpio_dir;
      @(posedge clk) disable iff (!arst_n)
      (!asleep && !alt_ff[0]) |=> (pinOe[0] == $past(dir_ff[0])) && (pinOut[0] == $past(outReg_ff[0]));
   endproperty
   a_gpio_dir: assert property (p_gpio_dir) else $error("general pin ignores software direction");

   property p_alt_dir;
      @(posedge clk) disable iff (!arst_n)
      (!asleep && alt_ff[1]) |=> (pinOe[1] == $past(periphOe[1]));
   endproperty
   a_alt_dir: assert property (p_alt_dir) else $error("peripheral does not own pin direction");

   property p_pull_reset;
      @(posedge clk) disable iff (!arst_n)
      $rose(arst_n) |-> (pullEn == ppsr_pkg::PULL_RESET);
   endproperty
   a_pull_reset: assert property (p_pull_reset) else $error("pull enables not set after reset");

   property p_open_drain;
      @(posedge clk) disable iff (!arst_n)
      (!asleep && twoWire) |=> !pinOut[ppsr_pkg::PIN_TW_A] && !pinOut[ppsr_pkg::PIN_TW_B];
   endproperty
   a_open_drain: assert property (p_open_drain) else $error("two-wire pin driven high");

   property p_reset_pins;
      @(posedge clk) disable iff (!arst_n)
      $rose(arst_n) |-> (pinOe == '0) && (periphEn == '0) && !adcEn && !cmpEn;
   endproperty
   a_reset_pins: assert property (p_reset_pins) else $error("pins or peripherals active out of reset");

   property p_retain;
      @(posedge clk) disable iff (!arst_n)
      (asleep && $past(asleep)) |-> $stable(pinOe) && $stable(pinOut);
   endproperty
   a_retain: assert property (p_retain) else $error("pin state moved during sleep");

   property p_wake;
      @(posedge clk) disable iff (!arst_n)
      (asleep && (|pinEvt)) ##1 asleep |-> wakeReq;
   endproperty
   a_wake: assert property (p_wake) else $error("enabled pin event did not wake");

   property p_analog_off;
      @(posedge clk) disable iff (!arst_n)
      (deepSleepReq || (sleepReq && !ctrl_ff[ppsr_pkg::CTRL_CMP_WAKE])) |=> !adcEn && !cmpEn;
   endproperty
   a_analog_off: assert property (p_analog_off) else $error("analog block on during sleep");

   property p_sync_delay;
      @(posedge clk) disable iff (!arst_n)
      $changed(pinIn[0]) ##1 1'b1 |=> (syncB_ff[0] == $past(pinIn[0], 2));
   endproperty
   a_sync_delay: assert property (p_sync_delay) else $error("input not seen two cycles later");

   property p_read_once;
      @(posedge clk) disable iff (!arst_n)
      !$past(regRd) |-> (regRdata == 32'h00000000);
   endproperty
   a_read_once: assert property (p_read_once) else $error("read data outside read cycle");

   property p_irq_level;
      @(posedge clk) disable iff (!arst_n)
      ((|(stat_ff & mask_ff)) && $stable(mask_ff)) |-> irq;
   endproperty
   a_irq_level: assert property (p_irq_level) else $error("unmasked status without interrupt");

   property p_wake_hold;
      @(posedge clk) disable iff (!arst_n)
      (wakeReq && asleep) |=> wakeReq;
   endproperty
   a_wake_hold: assert property (p_wake_hold) else $error("wake request dropped during sleep");

   property p_cmp_keep;
      @(posedge clk) disable iff (!arst_n)
      (sleepReq && !deepSleepReq && ctrl_ff[ppsr_pkg::CTRL_CMP_WAKE] && ctrl_ff[ppsr_pkg::CTRL_CMP_EN]) |=> cmpEn;
   endproperty
   a_cmp_keep: assert property (p_cmp_keep) else $error("comparator off although kept for wake");

   c_wake: cover property (@(posedge clk) disable iff (!arst_n) $rose(wakeReq));
   c_irq: cover property (@(posedge clk) disable iff (!arst_n) $rose(irq));
   c_twowire: cover property (@(posedge clk) disable iff (!arst_n) twoWire && pinOe[ppsr_pkg::PIN_TW_A]);
   c_cmp_sleep: cover property (@(posedge clk) disable iff (!arst_n) sleepReq && cmpEn);

endmodule : ppsr_port

/* File: tb/ppsr_pads.sv */
// pad-side model: external drivers, pull resistors and reset switch
// assumes a driving pad wins over any external driver
`timescale 1ns/100ps
module ppsr_pads (
   // clock
   input wire logic clk,
   // design pads
   input wire logic [19:0] pinOut,
   input wire logic [19:0] pinOe,
   input wire logic [19:0] pullEn,
   output logic [19:0] pinIn,
   // external circuit
   input wire logic [19:0] extDrv,
   input wire logic [19:0] extVal,
   input wire logic rstLow,
   output logic arst_n
);
   logic [19:0] floatLvl = 20'h00000;

   // undriven lines without pull wander every cycle
   always @(posedge clk) floatLvl <= ~floatLvl;

   assign arst_n = ~rstLow;

   always_comb begin
      for (int i = 0; i < 20; i++) begin
         if (pinOe[i]) pinIn[i] = pinOut[i];
         else if (extDrv[i]) pinIn[i] = extVal[i];
         else if (pullEn[i]) pinIn[i] = 1'b1;
         else pinIn[i] = floatLvl[i];
      end
   end
endmodule : ppsr_pads

/* File: tb/pin_port_with_sleep_retention_tb.sv */
// self-checking bench of the pin port
// assumes the pad model ppsr_pads on the pin side
`timescale 1ns/100ps
module pin_port_with_sleep_retention_tb;
   logic clk, rstLow, arst_n, regWr, regRd, sleepReq, deepSleepReq, cmpEvent, adcEn, cmpEn, wakeReq, irq, rdLag;
   logic [7:0] regAddr;
   logic [31:0] regWdata, regRdata, rnd;
   logic [19:0] pinIn, pinOut, pinOe, pullEn, periphEn, periphOe, periphOut, periphIn, extDrv, extVal, dirV, outV, v;
   logic [31:0] expQ[$];
   int bad_count, checked, cyc;

   ppsr_port uut (.clk(clk), .arst_n(arst_n), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
      .regRd(regRd), .regRdata(regRdata), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .pullEn(pullEn),
      .periphEn(periphEn), .periphOe(periphOe), .periphOut(periphOut), .periphIn(periphIn), .adcEn(adcEn),
      .cmpEn(cmpEn), .cmpEvent(cmpEvent), .sleepReq(sleepReq), .deepSleepReq(deepSleepReq),
      .wakeReq(wakeReq), .irq(irq));
   ppsr_pads pads (.clk(clk), .pinOut(pinOut), .pinOe(pinOe), .pullEn(pullEn), .pinIn(pinIn),
      .extDrv(extDrv), .extVal(extVal), .rstLow(rstLow), .arst_n(arst_n));

   // ***************************************************************
   // helpers
   // ***************************************************************
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic results();
      $display("checked=%0d bad=%0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : results

   task automatic step(input int n);
      repeat (n) @(posedge clk);
   endtask : step

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
      @(posedge clk);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      regAddr <= a;
      regRd <= 1'b1;
      expQ.push_back(exp);
      @(posedge clk);
      regRd <= 1'b0;
      @(posedge clk);
   endtask : rd

   task automatic resetCheck();
      check(32'(pinOe), 32'h0);
      check(32'(periphEn), 32'h0);
      check(32'(pullEn), 32'h000FFFFF);
      check(32'({adcEn, cmpEn, wakeReq, irq}), 32'h0);
   endtask : resetCheck

   // read data stand one cycle after the strobe
   always @(posedge clk) begin
      rdLag <= regRd;
      if (rdLag) check(regRdata, expQ.pop_front());
   end

   always @(posedge clk) begin
      cyc++;
      if (cyc > 3000) begin
         bad_count++;
         results();
      end
   end

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // ***************************************************************
   // main sequence
   // ***************************************************************
   initial begin
      rstLow = 1'b1;
      {regWr, regRd, sleepReq, deepSleepReq, cmpEvent} = 5'h0;
      regAddr = 8'h00;
      regWdata = 32'h0;
      {periphOe, periphOut, extVal} = 60'h0;
      extDrv = 20'hFFFFF;
      rnd = 32'hAB03;
      step(10);
      resetCheck();
      rstLow <= 1'b0;
      step(1);
      rd(ppsr_pkg::OFF_PULL, 32'h000FFFFF);
      rnd = lfsr(lfsr(rnd));
      dirV = rnd[19:0];
      outV = rnd[31:12];
      wr(ppsr_pkg::OFF_DIR, 32'(dirV));
      wr(ppsr_pkg::OFF_OUT, 32'(outV));
      wr(ppsr_pkg::OFF_PULL, 32'h0);
      step(1);
      check(32'(pinOe), 32'(dirV));
      check(32'(pinOut), 32'(outV));
      check(32'(pullEn), 32'h0);
      rd(ppsr_pkg::OFF_DIR, 32'(dirV));
      wr(8'h24, 32'hFFFFFFFF);
      rd(8'h24, 32'h0);
      $display("test gpio done");
      rnd = lfsr(lfsr(rnd));
      v = rnd[19:0] | 20'h00002;
      periphOe <= rnd[31:12];
      periphOut <= rnd[25:6];
      wr(ppsr_pkg::OFF_ALT, 32'(v));
      step(1);
      check(32'(periphEn), 32'(v));
      check(32'(pinOe), 32'((v & periphOe) | (~v & dirV)));
      check(32'(pinOut), 32'((v & periphOut) | (~v & outV)));
      wr(ppsr_pkg::OFF_ALT, 32'h0);
      $display("test alt done");
      wr(ppsr_pkg::OFF_DIR, 32'h0);
      rnd = lfsr(rnd);
      extVal <= rnd[19:0];
      step(3);
      rd(ppsr_pkg::OFF_IN, 32'(extVal));
      v = extVal;
      check(32'(periphIn), 32'(v));
      extVal <= ~v;
      rd(ppsr_pkg::OFF_IN, 32'(v));
      $display("test sync done");
      wr(ppsr_pkg::OFF_INTEN, 32'h8);
      wr(ppsr_pkg::OFF_MASK, 32'h8);
      extVal[3] <= v[3];
      step(5);
      check(32'(irq), 32'h1);
      rd(ppsr_pkg::OFF_STAT, 32'h8);
      wr(ppsr_pkg::OFF_MASK, 32'h0);
      step(1);
      check(32'(irq), 32'h0);
      wr(ppsr_pkg::OFF_MASK, 32'h8);
      step(1);
      check(32'(irq), 32'h1);
      wr(ppsr_pkg::OFF_STAT, 32'h8);
      step(1);
      check(32'(irq), 32'h0);
      $display("test irq done");
      wr(ppsr_pkg::OFF_CTRL, 32'h1);
      wr(ppsr_pkg::OFF_DIR, 32'h30);
      wr(ppsr_pkg::OFF_OUT, 32'h10);
      step(1);
      check(32'({pinOe[5:4], pinOut[5:4]}), 32'h8);
      wr(ppsr_pkg::OFF_DIR, 32'h0);
      extVal[5:4] <= 2'b11;
      step(12);
      v = extVal;
      extVal[4] <= 1'b0;
      step(3);
      rd(ppsr_pkg::OFF_IN, 32'(v));
      extVal[4] <= 1'b0;
      step(12);
      rd(ppsr_pkg::OFF_IN, 32'(v & 20'hFFFEF));
      extVal[5] <= 1'b0;
      step(3);
      extVal[5] <= 1'b1;
      step(12);
      rd(ppsr_pkg::OFF_IN, 32'(v & 20'hFFFEF));
      wr(ppsr_pkg::OFF_CTRL, 32'h0);
      $display("test twowire done");
      dirV = 20'h000F0;
      outV = 20'h000A0;
      wr(ppsr_pkg::OFF_DIR, 32'(dirV));
      wr(ppsr_pkg::OFF_OUT, 32'(outV));
      wr(ppsr_pkg::OFF_CTRL, 32'hE);
      step(1);
      check(32'({adcEn, cmpEn}), 32'h3);
      sleepReq <= 1'b1;
      step(2);
      check(32'({adcEn, cmpEn}), 32'h1);
      wr(ppsr_pkg::OFF_DIR, 32'h0);
      wr(ppsr_pkg::OFF_OUT, 32'h0);
      step(1);
      check(32'({pinOe, pinOut}), 32'({dirV, outV}));
      cmpEvent <= 1'b1;
      step(1);
      cmpEvent <= 1'b0;
      step(2);
      check(32'(wakeReq), 32'h1);
      sleepReq <= 1'b0;
      step(3);
      check(32'({wakeReq, pinOe}), 32'h0);
      wr(ppsr_pkg::OFF_DIR, 32'(dirV));
      step(1);
      deepSleepReq <= 1'b1;
      step(2);
      check(32'({adcEn, cmpEn}), 32'h0);
      wr(ppsr_pkg::OFF_DIR, 32'h0);
      step(1);
      check(32'(pinOe), 32'(dirV));
      extVal[3] <= ~extVal[3];
      step(5);
      check(32'(wakeReq), 32'h1);
      deepSleepReq <= 1'b0;
      step(3);
      $display("test sleep done");
      rstLow <= 1'b1;
      step(2);
      resetCheck();
      rstLow <= 1'b0;
      step(2);
      $display("test reset done");
      results();
   end
endmodule : pin_port_with_sleep_retention_tb
